/* ccr_comparator_ctrl.sv */
/*
 Digital control and status logic of an on-chip voltage comparator with a
 classic Wishbone register slave.
 Assumes: the analog comparator, input muxes and divider sit outside and
 take the configuration outputs; raw result and ready arrive asynchronously.
*/
// Chosen here: the Wishbone register port.

// Bus: a request is taken on an enabled edge while ack is low; ack and
// read data stand for exactly one cycle after that edge.
// Comparator path: raw result passes two sync stages, then the output
// register, so a pin change shows on the state bit three edges later.
// The output is forced to its initial value whenever the comparator is
// not both running and ready, so start-up noise never reaches the flag.
// Edge history and flag are frozen in standby, as the peripheral clock
// would be stopped there; an edge that spans standby is seen on wake.
// A hardware edge beats a software clear in the same cycle, so no edge
// is ever lost to a late clear.
// Limitation: standby and power-down inputs must come from this clock.
// Clock enable low freezes everything, including a pending bus answer.
`include "ccr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module ccr_comparator_ctrl (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:2] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Sleep state from power manager
   input wire logic standby_i,
   input wire logic powerdown_i,
   // Analog side, asynchronous
   input wire logic cmp_raw_i,
   input wire logic cmp_ready_i,
   // Analog configuration
   output logic cmp_enable_o,
   output logic [1:0] power_profile_o,
   output logic [1:0] hysteresis_select_o,
   output logic [2:0] positive_input_select_o,
   output logic [2:0] negative_input_select_o,
   output logic [7:0] reference_divider_value_o,
   // Output pad and internal level
   output logic cmp_out_o,
   output logic cmp_pad_oe_o,
   // Interrupt request
   output logic irq_o
);
   // State and its next value
   ccr_pkg::ccr_state_t st_ff;   // Registered state
   ccr_pkg::ccr_state_t nxt_st;  // Next state
   // Combinational decode, recomputed every cycle
   logic req;                    // New bus request this cycle
   logic wr_lane0;               // Write into low byte
   logic running;                // Comparator allowed to run
   logic out_val;                // Output level before registering
   logic rise;                   // Rising output edge
   logic fall;                   // Falling output edge
   logic edge_hit;               // Edge matches selected mode
   logic clr_flag;               // Software clears flag
   logic [7:0] rd_byte;          // Read mux result
   ccr_pkg::ccr_edge_t mode;     // Selected edge mode

   // Byte write to one register
   // Shared by every register write decode
   function automatic logic is_wr(input logic [2:0] adr, input logic [2:0] idx,
                                  input logic wr);
      is_wr = wr && (adr == idx);
   endfunction

   // Next-state logic
   always_comb begin
      nxt_st = st_ff;
      // A request held across ack is not taken a second time
      req = wb_cyc_i && wb_stb_i && !st_ff.ack;
      wr_lane0 = req && wb_we_i && wb_sel_i[0];
      // Edge mode straight from the register field
      mode = ccr_pkg::ccr_edge_t'(st_ff.intc[`CCR_INTC_MODE_HI:`CCR_INTC_MODE_LO]);
      // Halted in standby unless told to run; always off in power-down
      running = st_ff.ctrl[`CCR_CTRL_EN] && !powerdown_i
         && !(standby_i && !st_ff.ctrl[`CCR_CTRL_STBY]);
      // Raw result already means positive above negative
      // Inversion reaches the pin, the state bit and the flag alike
      out_val = st_ff.raw_s2 ^ st_ff.mux[`CCR_MUX_INV];
      if (!(running && st_ff.rdy_s2)) begin
         out_val = st_ff.mux[`CCR_MUX_INIT];
      end
      // Output edges, current sample against the previous one
      rise = st_ff.out_lvl && !st_ff.out_prev;
      fall = !st_ff.out_lvl && st_ff.out_prev;
      // Pick the edges that the mode asks for
      case (mode)
         ccr_pkg::CCR_EDGE_ANY: edge_hit = rise || fall;
         ccr_pkg::CCR_EDGE_FALL: edge_hit = fall;
         ccr_pkg::CCR_EDGE_RISE: edge_hit = rise;
         default: edge_hit = 1'b0; // Reserved code flags nothing
      endcase
      // Clear only on a written one in the low byte
      clr_flag = is_wr(wb_adr_i, `CCR_IDX_STAT, wr_lane0)
         && wb_dat_i[`CCR_STAT_FLAG];
      // Synchronisers; first stages feed only second stages
      nxt_st.raw_s1 = cmp_raw_i;
      nxt_st.raw_s2 = st_ff.raw_s1;
      nxt_st.rdy_s1 = cmp_ready_i;
      nxt_st.rdy_s2 = st_ff.rdy_s1;
      // Output register doubles as the state bit
      nxt_st.out_lvl = out_val;
      nxt_st.out_prev = st_ff.out_lvl;
      // Flag and edge history frozen while in standby since their clock would be stopped
      if (!standby_i) begin
         // Set beats clear so a coinciding edge is kept
         if (edge_hit) begin
            nxt_st.flag = 1'b1;
         end else if (clr_flag) begin
            nxt_st.flag = 1'b0;
         end
      end else begin
         nxt_st.out_prev = st_ff.out_prev;
      end
      // Register writes, low byte only
      // Control register
      if (is_wr(wb_adr_i, `CCR_IDX_CTRL, wr_lane0)) begin
         nxt_st.ctrl = wb_dat_i[7:0];
         nxt_st.ctrl[5] = 1'b0; // Unused bit stays zero
      end
      // Input select register
      if (is_wr(wb_adr_i, `CCR_IDX_MUX, wr_lane0)) begin
         nxt_st.mux = wb_dat_i[7:0];
      end
      // Divider value
      if (is_wr(wb_adr_i, `CCR_IDX_DREF, wr_lane0)) begin
         nxt_st.dref = wb_dat_i[7:0];
      end
      // Interrupt control, only mode and enable bits kept
      if (is_wr(wb_adr_i, `CCR_IDX_INTC, wr_lane0)) begin
         nxt_st.intc = wb_dat_i[7:0] & 8'h31;
      end
      // Read mux; unmapped indices read zero
      // Status shows state in bit four and flag in bit zero
      case (wb_adr_i)
         `CCR_IDX_CTRL: rd_byte = st_ff.ctrl;
         `CCR_IDX_MUX: rd_byte = st_ff.mux;
         `CCR_IDX_DREF: rd_byte = st_ff.dref;
         `CCR_IDX_INTC: rd_byte = st_ff.intc;
         `CCR_IDX_STAT: rd_byte = {3'h0, st_ff.out_lvl, 3'h0, st_ff.flag};
         default: rd_byte = 8'h00;
      endcase
      // Every request answered one cycle later, unmapped too
      nxt_st.ack = req;
      nxt_st.dat = req ? {24'h000000, rd_byte} : 32'h00000000;
      // Registered outputs
      nxt_st.ana_en = running;
      // Pad drive lags its register bit by one cycle
      nxt_st.pad_oe = st_ff.ctrl[`CCR_CTRL_PADEN] && !powerdown_i;
      // Request tracks the flag until software clears it
      nxt_st.irq = st_ff.flag && st_ff.intc[`CCR_INTC_IE];
   end

   // State register, frozen when clock enable is low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // Whole state cleared first, then register defaults
         st_ff <= '0;
         st_ff.ctrl <= `CCR_RST_CTRL;
         st_ff.mux <= `CCR_RST_MUX;
         st_ff.dref <= `CCR_RST_DREF;
         st_ff.intc <= `CCR_RST_INTC;
      // Clock enable low holds every bit
      end else if (ce_i) begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from state flip-flops
   // Bus answer
   assign wb_dat_o = st_ff.dat;
   assign wb_ack_o = st_ff.ack;
   // Analog configuration; enable from the registered running decode, the rest direct from register bits
   assign cmp_enable_o = st_ff.ana_en;
   assign power_profile_o = st_ff.ctrl[`CCR_CTRL_PWR_HI:`CCR_CTRL_PWR_LO];
   assign hysteresis_select_o = st_ff.ctrl[`CCR_CTRL_HYS_HI:`CCR_CTRL_HYS_LO];
   assign positive_input_select_o = st_ff.mux[`CCR_MUX_POS_HI:`CCR_MUX_POS_LO];
   assign negative_input_select_o = st_ff.mux[`CCR_MUX_NEG_HI:`CCR_MUX_NEG_LO];
   assign reference_divider_value_o = st_ff.dref;
   // Output level and pad drive
   assign cmp_out_o = st_ff.out_lvl;
   assign cmp_pad_oe_o = st_ff.pad_oe;
   // Interrupt request
   assign irq_o = st_ff.irq;

   // Checks
   // All checks run on the one clock and rest during reset
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Request is the registered flag and enable
   chk_irq_follows_flag: assert property (ce_i ##1 1'b1 |-> irq_o ==
      $past(st_ff.flag && st_ff.intc[`CCR_INTC_IE])) else $error("irq mismatch");
   // Flag only falls on a clear
   chk_flag_sticky: assert property (ce_i && st_ff.flag && !clr_flag
      |=> st_ff.flag) else $error("flag dropped without clear");
   // Written one clears the flag
   chk_flag_clear: assert property (ce_i && clr_flag && !edge_hit && !standby_i
      |=> !st_ff.flag) else $error("flag not cleared");
   // Selected edge sets the flag outside standby, even against a clear
   chk_set_wins: assert property (ce_i && edge_hit && !standby_i
      |=> st_ff.flag) else $error("edge lost");
   // Standby holds the flag
   chk_standby_freeze: assert property (ce_i && standby_i
      |=> st_ff.flag == $past(st_ff.flag)) else $error("flag moved in standby");
   // Not ready means initial value
   chk_init_value: assert property (ce_i && !st_ff.rdy_s2
      |=> cmp_out_o == $past(st_ff.mux[`CCR_MUX_INIT])) else $error("init value");
   // Three edges from pin to state bit
   chk_sync_delay: assert property (ce_i [*3] ##0 running && st_ff.rdy_s2
      && !st_ff.mux[`CCR_MUX_INV] |=> cmp_out_o == $past(cmp_raw_i, 3))
      else $error("state delay");
   // Power-down drops enable and pad drive
   chk_powerdown_off: assert property (ce_i && powerdown_i
      |=> !cmp_enable_o && !cmp_pad_oe_o) else $error("power-down drive");
   // Standby halts unless told to run
   chk_standby_halt: assert property (ce_i && standby_i
      && !st_ff.ctrl[`CCR_CTRL_STBY] |=> !cmp_enable_o) else $error("standby run");
   // Every request answered one cycle later
   chk_bus_ack: assert property (ce_i && req |=> wb_ack_o ##1 (!wb_ack_o || !ce_i))
      else $error("ack timing");
   // Reserved mode never flags
   chk_reserved_mode: assert property (ce_i && mode == ccr_pkg::CCR_EDGE_RSVD
      && !st_ff.flag && !standby_i |=> !st_ff.flag) else $error("reserved flagged");

   // Register and bus checks
   // Ack stands one cycle only
   chk_ack_pulse: assert property (ce_i && wb_ack_o
      |=> !wb_ack_o) else $error("ack held");
   // Read data is zero outside an answer
   chk_idle_data: assert property (ce_i && !req
      |=> wb_dat_o == 32'h00000000) else $error("stale read data");
   // State bit read back from the output level
   chk_state_read: assert property (ce_i && req && !wb_we_i
      && wb_adr_i == `CCR_IDX_STAT |=> wb_dat_o[`CCR_STAT_STATE] == $past(st_ff.out_lvl))
      else $error("state bit read");
   // Flag read back in bit zero
   chk_flag_read: assert property (ce_i && req && !wb_we_i
      && wb_adr_i == `CCR_IDX_STAT |=> wb_dat_o[`CCR_STAT_FLAG] == $past(st_ff.flag))
      else $error("flag read");
   // Zero written to the flag leaves it alone
   chk_zero_write: assert property (ce_i && wr_lane0 && wb_adr_i == `CCR_IDX_STAT
      && !wb_dat_i[`CCR_STAT_FLAG] && !edge_hit |=> st_ff.flag == $past(st_ff.flag))
      else $error("zero write moved flag");
   // Divider value reaches its output
   chk_divider_out: assert property (ce_i && wr_lane0 && wb_adr_i == `CCR_IDX_DREF
      |=> reference_divider_value_o == $past(wb_dat_i[7:0]))
      else $error("divider output");
   // Power profile field reaches its output
   chk_profile_out: assert property (ce_i && wr_lane0 && wb_adr_i == `CCR_IDX_CTRL
      |=> power_profile_o == $past(wb_dat_i[`CCR_CTRL_PWR_HI:`CCR_CTRL_PWR_LO]))
      else $error("power profile output");
   // Hysteresis field reaches its output
   chk_hys_out: assert property (ce_i && wr_lane0 && wb_adr_i == `CCR_IDX_CTRL
      |=> hysteresis_select_o == $past(wb_dat_i[`CCR_CTRL_HYS_HI:`CCR_CTRL_HYS_LO]))
      else $error("hysteresis output");
   // Both input selects reach their outputs
   chk_select_out: assert property (ce_i && wr_lane0 && wb_adr_i == `CCR_IDX_MUX
      |=> {positive_input_select_o, negative_input_select_o} == $past(wb_dat_i[5:0]))
      else $error("input select output");

   // Comparator path checks
   // Enable bit turns the comparator on
   chk_enable_on: assert property (ce_i && st_ff.ctrl[`CCR_CTRL_EN]
      && !powerdown_i && !standby_i |=> cmp_enable_o) else $error("enable lost");
   // Cleared enable bit keeps it off
   chk_enable_off: assert property (ce_i && !st_ff.ctrl[`CCR_CTRL_EN]
      |=> !cmp_enable_o) else $error("enabled while off");
   // Standby run keeps the comparator on
   chk_standby_run: assert property (ce_i && standby_i && st_ff.ctrl[`CCR_CTRL_STBY]
      && st_ff.ctrl[`CCR_CTRL_EN] && !powerdown_i |=> cmp_enable_o)
      else $error("halted despite standby run");
   // Pad drive follows its bit one cycle late
   chk_pad_drive: assert property (ce_i
      |=> cmp_pad_oe_o == $past(st_ff.ctrl[`CCR_CTRL_PADEN] && !powerdown_i))
      else $error("pad drive mismatch");
   // Running and ready output is raw result, inverted on request
   chk_invert_out: assert property (ce_i && running && st_ff.rdy_s2
      |=> cmp_out_o == $past(st_ff.raw_s2 ^ st_ff.mux[`CCR_MUX_INV]))
      else $error("inversion mismatch");
   // Halted comparator shows the initial value
   chk_forced_init: assert property (ce_i && !running
      |=> cmp_out_o == $past(st_ff.mux[`CCR_MUX_INIT])) else $error("forced value");
   // Disabled interrupt never requests
   chk_irq_disabled: assert property (ce_i && !st_ff.intc[`CCR_INTC_IE]
      |=> !irq_o) else $error("irq while disabled");
   // Rising mode ignores everything but rises
   chk_rise_only: assert property (ce_i && mode == ccr_pkg::CCR_EDGE_RISE
      && !rise && !st_ff.flag |=> !st_ff.flag) else $error("rise mode flagged");
   // Falling mode ignores everything but falls
   chk_fall_only: assert property (ce_i && mode == ccr_pkg::CCR_EDGE_FALL
      && !fall && !st_ff.flag |=> !st_ff.flag) else $error("fall mode flagged");

   // Covers of the main scenarios
   cov_rise_flag: cover property (mode == ccr_pkg::CCR_EDGE_RISE && rise ##1 st_ff.flag);
   cov_clear: cover property (st_ff.flag ##1 clr_flag ##1 !st_ff.flag);
   cov_irq: cover property (irq_o);
   cov_set_clear_same: cover property (edge_hit && clr_flag);
   cov_standby_run: cover property (standby_i && st_ff.ctrl[`CCR_CTRL_STBY] && cmp_enable_o);
endmodule
`default_nettype wire

/* ccr_defines.svh */
/*
 Register indices, field positions, reset values and timing counts of the
 comparator control block.
 Assumes: included by bare name by the package and the design.
*/
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH
// Register indices; byte address is four times the index
`define CCR_IDX_CTRL 3'h0
`define CCR_IDX_MUX 3'h2
`define CCR_IDX_DREF 3'h5
`define CCR_IDX_INTC 3'h6
`define CCR_IDX_STAT 3'h7
// Reset values
`define CCR_RST_CTRL 8'h00
`define CCR_RST_MUX 8'h00
`define CCR_RST_DREF 8'hFF
`define CCR_RST_INTC 8'h00
// Control register fields
`define CCR_CTRL_STBY 7
`define CCR_CTRL_PADEN 6
`define CCR_CTRL_PWR_HI 4
`define CCR_CTRL_PWR_LO 3
`define CCR_CTRL_HYS_HI 2
`define CCR_CTRL_HYS_LO 1
`define CCR_CTRL_EN 0
// Input select register fields
`define CCR_MUX_INV 7
`define CCR_MUX_INIT 6
`define CCR_MUX_POS_HI 5
`define CCR_MUX_POS_LO 3
`define CCR_MUX_NEG_HI 2
`define CCR_MUX_NEG_LO 0
// Interrupt control and status fields
`define CCR_INTC_MODE_HI 5
`define CCR_INTC_MODE_LO 4
`define CCR_INTC_IE 0
`define CCR_STAT_STATE 4
`define CCR_STAT_FLAG 0
// Divider full scale, documented for the reference formula
`define CCR_DREF_SCALE 256
// Cycles from raw input to state bit
`define CCR_SYNC_DELAY 3
`endif

/* ccr_pkg.sv */
/*
 Types of the comparator control block.
 Assumes: ccr_defines.svh is on the include path.
*/
`include "ccr_defines.svh"
package ccr_pkg;
   // Interrupt edge selection codes
   typedef enum logic [1:0] {
      CCR_EDGE_ANY = 2'h0,
      CCR_EDGE_RSVD = 2'h1,
      CCR_EDGE_FALL = 2'h2,
      CCR_EDGE_RISE = 2'h3
   } ccr_edge_t;
   // Whole state of the block
   typedef struct packed {
      logic [7:0] ctrl;      // Comparator control
      logic [7:0] mux;       // Input select control
      logic [7:0] dref;      // Reference divider value
      logic [7:0] intc;      // Interrupt control
      logic flag;            // Interrupt flag
      logic raw_s1;          // Raw result sync stage one
      logic raw_s2;          // Raw result sync stage two
      logic rdy_s1;          // Ready sync stage one
      logic rdy_s2;          // Ready sync stage two
      logic out_lvl;         // Output level, also state bit
      logic out_prev;        // Previous output level
      logic ana_en;          // Analog enable output
      logic pad_oe;          // Pad drive enable output
      logic irq;             // Interrupt request output
      logic ack;             // Bus acknowledge
      logic [31:0] dat;      // Bus read data
   } ccr_state_t;
endpackage

/* ccr_analog_model.sv */
/*
 Stand-in for the analog comparator and its input muxes, pin levels in mV.
 Assumes: selects, divider and enable come from the control block.
*/
`timescale 1ns/10ps
`default_nettype none
module ccr_analog_model (
   // Clock and configuration
   input wire logic clk_i,
   input wire logic en_i,
   input wire logic [2:0] pos_i,
   input wire logic [2:0] neg_i,
   input wire logic [7:0] dref_i,
   // Pin levels: p3, p4, n2, n3
   input wire logic [3:0][11:0] mv_i,
   // Result towards the block
   output logic raw_o,
   output logic ready_o
);
   logic [2:0] cnt = 3'h0; // Start-up count
   logic wob = 1'b0; // Junk level while off
   logic [11:0] vp;
   logic [11:0] vn;
   // Reserved positive codes give 0 V
   assign vp = pos_i == 3'h3 ? mv_i[0] : pos_i == 3'h4 ? mv_i[1] : 12'h000;
   // Divider on a 2048 mV reference; reserved codes sit at full scale
   assign vn = neg_i == 3'h2 ? mv_i[2] : neg_i == 3'h3 ? mv_i[3] :
      neg_i == 3'h4 ? {1'b0, dref_i, 3'h0} : 12'hFFF;
   // Off comparator wobbles, so an unforced output shows at once
   assign raw_o = en_i ? (vp > vn) : wob;
   // Ready only after a start-up wait
   always @(posedge clk_i) begin
      cnt <= en_i ? (cnt == 3'h4 ? cnt : cnt + 3'h1) : 3'h0;
      ready_o <= en_i && cnt == 3'h4;
      wob <= ~wob;
   end
endmodule
`default_nettype wire

/* test_ccr_comparator_ctrl.sv */
/*
 Self-checking bench of the comparator control block.
 Assumes: design and analog stand-in are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module test_ccr_comparator_ctrl;
   logic clk_i = 1'b0; // 100 MHz
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [2:0] adr = 3'h0;
   logic [31:0] wdat = 32'h0;
   logic stby = 1'b0;
   logic pdn = 1'b0;
   logic [3:0][11:0] mv = {12'd700, 12'd500, 12'd200, 12'd1000}; // Pin levels
   logic [31:0] rdat;
   logic ack, raw, rdy, en, out, oe, irq;
   logic [1:0] pwr, hys;
   logic [2:0] psel, nsel;
   logic [7:0] dref, q;
   int n_errors = 0;
   int n_checks = 0;

   // Clock
   initial forever #5 clk_i = ~clk_i;

   ccr_comparator_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .standby_i(stby), .powerdown_i(pdn),
      .cmp_raw_i(raw), .cmp_ready_i(rdy), .cmp_enable_o(en), .power_profile_o(pwr),
      .hysteresis_select_o(hys), .positive_input_select_o(psel),
      .negative_input_select_o(nsel), .reference_divider_value_o(dref),
      .cmp_out_o(out), .cmp_pad_oe_o(oe), .irq_o(irq));
   ccr_analog_model ana (.clk_i(clk_i), .en_i(en), .pos_i(psel), .neg_i(nsel),
      .dref_i(dref), .mv_i(mv), .raw_o(raw), .ready_o(rdy));

   task give_verdict();
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Wait n edges, then let their updates land
   task tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One classic cycle; request held until ack is sampled
   task wb(input logic w, input logic [2:0] a, input logic [7:0] d);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      for (i = 0; i < 16 && ack !== 1'b1; i++) @(posedge clk_i);
      if (ack !== 1'b1) begin
         n_errors++;
         give_verdict();
      end
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] exp);
      wb(1'b0, a, 8'h00);
      chk(q, exp);
   endtask

   // Reset values and an unmapped index
   task t_regs();
      rd(3'h0, 8'h00);
      rd(3'h2, 8'h00);
      rd(3'h5, 8'hFF);
      rd(3'h6, 8'h00);
      rd(3'h7, 8'h00);
      rd(3'h1, 8'h00);
      chk(dref, 8'hFF);
      $display("test regs done");
   endtask
   // Every power and hysteresis code, enable bit
   task t_ctrl();
      int i;
      for (i = 0; i < 4; i++) begin
         wb(1'b1, 3'h0, 8'(i * 10 + 1));
         tick(1);
         chk({6'h0, pwr}, 8'(i));
         chk({6'h0, hys}, 8'(i));
         chk({7'h0, en}, 8'h01);
      end
      wb(1'b1, 3'h0, 8'hFF);
      rd(3'h0, 8'hDF);
      wb(1'b1, 3'h0, 8'h00);
      $display("test ctrl done");
   endtask
   // Initial value, muxes, inversion, divider, sync delay
   task t_path();
      wb(1'b1, 3'h2, 8'h1A);
      wb(1'b1, 3'h0, 8'h41);
      tick(1);
      chk({7'h0, out}, 8'h00);
      tick(12);
      chk({7'h0, out}, 8'h01);
      chk({7'h0, oe}, 8'h01);
      rd(3'h7, 8'h11);
      wb(1'b1, 3'h2, 8'h22);
      tick(6);
      chk({7'h0, out}, 8'h00);
      wb(1'b1, 3'h2, 8'h1B);
      tick(6);
      chk({7'h0, out}, 8'h01);
      wb(1'b1, 3'h2, 8'h9B);
      tick(6);
      chk({7'h0, out}, 8'h00);
      wb(1'b1, 3'h2, 8'h1C);
      wb(1'b1, 3'h5, 8'h80);
      tick(6);
      chk({7'h0, out}, 8'h00);
      wb(1'b1, 3'h5, 8'h60);
      tick(6);
      chk({7'h0, out}, 8'h01);
      @(posedge clk_i);
      mv[0] <= 12'd100;
      tick(2);
      chk({7'h0, out}, 8'h01);
      tick(1);
      chk({7'h0, out}, 8'h00);
      $display("test path done");
   endtask
   // Each edge mode, rising then falling, flag hold and clear
   task t_irq();
      int m;
      logic r, f;
      wb(1'b1, 3'h2, 8'h1A);
      for (m = 0; m < 4; m++) begin
         r = (m == 0 || m == 3);
         f = (m == 0 || m == 2);
         wb(1'b1, 3'h6, {2'h0, 2'(m), 4'h1});
         tick(4);
         wb(1'b1, 3'h7, 8'h01);
         @(posedge clk_i);
         mv[0] <= 12'd1000;
         tick(6);
         chk({7'h0, irq}, {7'h0, r});
         rd(3'h7, {3'h0, 1'b1, 3'h0, r});
         wb(1'b1, 3'h7, 8'h10);
         rd(3'h7, {3'h0, 1'b1, 3'h0, r});
         chk({7'h0, irq}, {7'h0, r});
         wb(1'b1, 3'h7, 8'h01);
         tick(1);
         chk({7'h0, irq}, 8'h00);
         rd(3'h7, 8'h10);
         @(posedge clk_i);
         mv[0] <= 12'd100;
         tick(6);
         rd(3'h7, {7'h0, f});
      end
      $display("test irq done");
   endtask
   // Standby run, frozen flag, power-down
   task t_sleep();
      wb(1'b1, 3'h7, 8'h01);
      @(posedge clk_i);
      stby <= 1'b1;
      tick(2);
      chk({7'h0, en}, 8'h00);
      wb(1'b1, 3'h0, 8'hC1);
      tick(2);
      chk({7'h0, en}, 8'h01);
      @(posedge clk_i);
      mv[0] <= 12'd1000;
      tick(8);
      chk({7'h0, irq}, 8'h00);
      @(posedge clk_i);
      stby <= 1'b0;
      pdn <= 1'b1;
      tick(2);
      chk({6'h0, en, oe}, 8'h00);
      $display("test sleep done");
   endtask

   // Main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_ctrl();
      t_path();
      t_irq();
      t_sleep();
      give_verdict();
   end
endmodule
`default_nettype wire
